// ===== design/efh_frame.sv
/*
 * Frame transmit and receive with register port.
 * Assumes held transmit valid and idle gaps between received frames.
 */
module efh_frame
(
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [efh_pkg::ADDR_W-1:0] i_reg_addr,
   input wire logic [efh_pkg::DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [efh_pkg::DATA_W-1:0] o_reg_rdata,
   input wire efh_pkg::efh_byte_type i_tx_byte,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   output logic [7:0] o_line_tx_data,
   output logic o_line_tx_en,
   input wire logic [7:0] i_line_rx_data,
   input wire logic i_line_rx_dv,
   output efh_pkg::efh_byte_type o_rx_byte,
   output logic o_rx_valid,
   output logic o_rx_end,
   output efh_pkg::efh_rx_status_type o_rx_status
);
   import efh_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   logic [2:0] pad_cfg_reg;
   logic huge_en_reg;
   logic [7:0] filter_ctrl_reg;
   logic [47:0] station_reg;
   logic tx_oversize_reg;
   efh_tx_state_type tx_state_reg, tx_state_next;
   logic [CNT_W-1:0] tx_cnt_reg, tx_cnt_next;
   logic [2:0] tx_pre_reg, tx_pre_next;
   logic [1:0] tx_fcs_reg, tx_fcs_next;
   logic [7:0] tx_data_next;
   logic tx_en_next, tx_crc_valid, tx_crc_clear, tx_trunc;
   logic [31:0] tx_crc;
   logic tx_take, tx_pad_en, tx_crc_en;
   efh_rx_state_type rx_state_reg, rx_state_next;
   logic [CNT_W-1:0] rx_cnt_reg;
   logic [4:0] rx_ptr_reg;
   logic [4:0] rx_flush_reg;
   logic [7:0] rx_delay_mem [DELAY_LEN];
   logic [47:0] rx_dest_reg;
   logic [15:0] rx_type_reg;
   logic rx_oversize_reg;
   logic rx_byte_in, rx_crc_clear;
   logic [31:0] rx_crc;
   efh_class_type rx_class;
   logic rx_accept, rx_emit_ok, rx_crc_ok;

   // ****************************************
   // Pad configuration decode
   // ****************************************
   function automatic logic pad_selected(input logic [2:0] cfg);
      return cfg[PAD_EN_BIT];
   endfunction

   function automatic logic crc_selected(input logic [2:0] cfg);
      return cfg != PAD_CFG_RESET;
   endfunction

   assign tx_pad_en = pad_selected(pad_cfg_reg);
   assign tx_crc_en = crc_selected(pad_cfg_reg);

   // ****************************************
   // Register port
   // ****************************************
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         pad_cfg_reg <= PAD_CFG_RESET;
         huge_en_reg <= 1'b0;
         filter_ctrl_reg <= RX_FILTER_RESET;
         station_reg <= '0;
      end
      else if (i_reg_wr)
      begin
         case (i_reg_addr)
            REG_MAC_CTRL:
            begin
               pad_cfg_reg <= i_reg_wdata[PAD_CFG_LSB +: 3];
               huge_en_reg <= i_reg_wdata[HUGE_EN_BIT];
            end
            REG_RX_FILTER: filter_ctrl_reg <= i_reg_wdata[7:0];
            REG_STATION_LO: station_reg[31:0] <= i_reg_wdata;
            REG_STATION_HI: station_reg[47:32] <= i_reg_wdata[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         o_reg_rdata <= '0;
      end
      else if (i_reg_rd)
      begin
         case (i_reg_addr)
            REG_MAC_CTRL: o_reg_rdata <= {28'h0000000, huge_en_reg, pad_cfg_reg};
            REG_RX_FILTER: o_reg_rdata <= {24'h000000, filter_ctrl_reg};
            REG_STATION_LO: o_reg_rdata <= station_reg[31:0];
            REG_STATION_HI: o_reg_rdata <= {16'h0000, station_reg[47:32]};
            REG_STATUS: o_reg_rdata <= {24'h000000, tx_oversize_reg, (rx_state_reg != RX_IDLE),
                                        (tx_state_reg != TX_IDLE), o_rx_status[4:0]};
            default: o_reg_rdata <= '0;
         endcase
      end
      else
      begin
         o_reg_rdata <= '0;
      end
   end

   // ****************************************
   // Transmit framing
   // ****************************************
   assign tx_take = (tx_state_reg == TX_DATA) && o_tx_ready && i_tx_valid;
   assign tx_trunc = (tx_cnt_reg >= MAX_FRAME_NO_FCS) && !huge_en_reg; // see R11

   always_comb
   begin
      tx_state_next = tx_state_reg;
      tx_cnt_next = tx_cnt_reg;
      tx_pre_next = tx_pre_reg;
      tx_fcs_next = tx_fcs_reg;
      tx_data_next = PAD_BYTE;
      tx_en_next = 1'b0;
      tx_crc_valid = 1'b0;
      tx_crc_clear = 1'b0;
      case (tx_state_reg)
         TX_IDLE:
         begin
            tx_crc_clear = 1'b1;
            tx_cnt_next = '0;
            tx_pre_next = '0;
            tx_fcs_next = '0;
            if (i_tx_valid)
            begin
               tx_state_next = TX_PRE;
            end
         end
         TX_PRE:
         begin
            tx_data_next = PREAMBLE_BYTE; // see R1, R2
            tx_en_next = 1'b1;
            tx_pre_next = tx_pre_reg + 3'h1;
            if (tx_pre_reg == PREAMBLE_LAST)
            begin
               tx_state_next = TX_SFD;
            end
         end
         TX_SFD:
         begin
            tx_data_next = SFD_BYTE; // see R1, R2
            tx_en_next = 1'b1;
            tx_state_next = TX_DATA;
         end
         TX_DATA:
         begin
            if (tx_take && !tx_trunc)
            begin
               // see R9, R20
               tx_data_next = i_tx_byte.data;
               tx_en_next = 1'b1;
               tx_crc_valid = 1'b1;
               tx_cnt_next = tx_cnt_reg + 16'h0001;
            end
            if (tx_take && i_tx_byte.last)
            begin
               if (tx_pad_en && (tx_cnt_next < MIN_FRAME_NO_FCS))
               begin
                  tx_state_next = TX_PAD; // see R12, R13
               end
               else if (tx_crc_en)
               begin
                  tx_state_next = TX_FCS; // see R19
               end
               else
               begin
                  tx_state_next = TX_IDLE; // see R14
               end
            end
         end
         TX_PAD:
         begin
            tx_data_next = PAD_BYTE; // see R13
            tx_en_next = 1'b1;
            tx_crc_valid = 1'b1;
            tx_cnt_next = tx_cnt_reg + 16'h0001;
            if (tx_cnt_next >= MIN_FRAME_NO_FCS)
            begin
               tx_state_next = tx_crc_en ? TX_FCS : TX_IDLE;
            end
         end
         TX_FCS:
         begin
            tx_data_next = ~tx_crc[{tx_fcs_reg, 3'h0} +: 8]; // see R19, R20
            tx_en_next = 1'b1;
            tx_fcs_next = tx_fcs_reg + 2'h1;
            if (tx_fcs_reg == FCS_LAST)
            begin
               tx_state_next = TX_IDLE;
            end
         end
         default: tx_state_next = TX_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         tx_state_reg <= TX_IDLE;
         tx_cnt_reg <= '0;
         tx_pre_reg <= '0;
         tx_fcs_reg <= '0;
         o_tx_ready <= 1'b0;
         o_line_tx_data <= '0;
         o_line_tx_en <= 1'b0;
      end
      else
      begin
         tx_state_reg <= tx_state_next;
         tx_cnt_reg <= tx_cnt_next;
         tx_pre_reg <= tx_pre_next;
         tx_fcs_reg <= tx_fcs_next;
         o_tx_ready <= (tx_state_next == TX_DATA);
         o_line_tx_data <= tx_data_next;
         o_line_tx_en <= tx_en_next;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         tx_oversize_reg <= 1'b0;
      end
      else if (tx_take && tx_trunc)
      begin
         tx_oversize_reg <= 1'b1;
      end
      else if (i_reg_rd && (i_reg_addr == REG_STATUS))
      begin
         tx_oversize_reg <= 1'b0;
      end
   end

   efh_crc32 u_tx_crc
   (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_clear(tx_crc_clear),
      .i_valid(tx_crc_valid),
      .i_data(tx_data_next),
      .o_crc(tx_crc)
   );

   // ****************************************
   // Receive delimiter stripping
   // ****************************************
   assign rx_byte_in = (rx_state_reg == RX_DATA) && i_line_rx_dv;
   assign rx_crc_clear = (rx_state_reg == RX_PRE);

   always_comb
   begin
      rx_state_next = rx_state_reg;
      case (rx_state_reg)
         RX_IDLE:
         begin
            if (i_line_rx_dv && (i_line_rx_data == PREAMBLE_BYTE))
            begin
               rx_state_next = RX_PRE;
            end
         end
         RX_PRE:
         begin
            if (!i_line_rx_dv || ((i_line_rx_data != PREAMBLE_BYTE) && (i_line_rx_data != SFD_BYTE)))
            begin
               rx_state_next = RX_IDLE;
            end
            else if (i_line_rx_data == SFD_BYTE)
            begin
               rx_state_next = RX_DATA; // see R1, R2
            end
         end
         RX_DATA:
         begin
            if (!i_line_rx_dv)
            begin
               // see R15, R16
               rx_state_next = (rx_cnt_reg >= RUNT_LEN) ? RX_FLUSH : RX_IDLE;
            end
         end
         RX_FLUSH:
         begin
            if (rx_flush_reg == DELAY_LAST)
            begin
               rx_state_next = RX_IDLE;
            end
         end
         default: rx_state_next = RX_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         rx_state_reg <= RX_IDLE;
      end
      else
      begin
         rx_state_reg <= rx_state_next;
      end
   end

   // ****************************************
   // Receive capture and delay line
   // ****************************************
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst || rx_crc_clear)
      begin
         rx_cnt_reg <= '0;
         rx_ptr_reg <= '0;
         rx_flush_reg <= '0;
         rx_oversize_reg <= 1'b0;
      end
      else if (rx_byte_in)
      begin
         if (rx_cnt_reg != '1)
         begin
            rx_cnt_reg <= rx_cnt_reg + 16'h0001;
         end
         if (rx_cnt_reg >= MAX_FRAME && !huge_en_reg)
         begin
            rx_oversize_reg <= 1'b1; // see R11
         end
         rx_ptr_reg <= (rx_ptr_reg == DELAY_LAST) ? 5'h00 : rx_ptr_reg + 5'h01;
      end
      else if (rx_state_reg == RX_FLUSH)
      begin
         rx_flush_reg <= rx_flush_reg + 5'h01;
         rx_ptr_reg <= (rx_ptr_reg == DELAY_LAST) ? 5'h00 : rx_ptr_reg + 5'h01;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (rx_byte_in)
      begin
         rx_delay_mem[rx_ptr_reg] <= i_line_rx_data; // see R3
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         rx_dest_reg <= '0;
         rx_type_reg <= '0;
      end
      else if (rx_byte_in)
      begin
         if (rx_cnt_reg < DEST_LEN)
         begin
            rx_dest_reg <= {rx_dest_reg[39:0], i_line_rx_data}; // see R20
         end
         if (rx_cnt_reg == TYPE_HI_POS)
         begin
            rx_type_reg[15:8] <= i_line_rx_data;
         end
         if (rx_cnt_reg == TYPE_LO_POS)
         begin
            rx_type_reg[7:0] <= i_line_rx_data;
         end
      end
   end

   efh_crc32 u_rx_crc
   (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_clear(rx_crc_clear),
      .i_valid(rx_byte_in),
      .i_data(i_line_rx_data),
      .o_crc(rx_crc)
   );

   efh_addr_filter u_filter
   (
      .i_dest(rx_dest_reg),
      .i_station(station_reg),
      .i_filter_ctrl(filter_ctrl_reg),
      .o_class(rx_class),
      .o_accept(rx_accept)
   );

   // ****************************************
   // Receive output to host
   // ****************************************
   assign rx_emit_ok = rx_accept && !rx_oversize_reg; // see R7
   assign rx_crc_ok = (rx_crc == CRC_RESIDUE); // see R18

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         o_rx_byte <= '0;
         o_rx_valid <= 1'b0;
         o_rx_end <= 1'b0;
         o_rx_status <= '0;
      end
      else
      begin
         o_rx_valid <= 1'b0;
         o_rx_end <= 1'b0;
         if (rx_byte_in && (rx_cnt_reg >= DELAY_LEN) && rx_emit_ok)
         begin
            o_rx_byte <= '{data: rx_delay_mem[rx_ptr_reg], last: 1'b0};
            o_rx_valid <= 1'b1;
         end
         else if ((rx_state_reg == RX_FLUSH) && rx_emit_ok)
         begin
            o_rx_byte <= '{data: rx_delay_mem[rx_ptr_reg], last: (rx_flush_reg == DELAY_LAST)};
            o_rx_valid <= 1'b1;
            if (rx_flush_reg == DELAY_LAST)
            begin
               o_rx_end <= 1'b1;
               o_rx_status.good <= rx_crc_ok || !filter_ctrl_reg[FLT_CRC_BIT]; // see R18
               o_rx_status.crc_ok <= rx_crc_ok;
               o_rx_status.oversize <= rx_oversize_reg;
               o_rx_status.length_field <= (rx_type_reg <= TYPE_LEN_MAX); // see R10
               o_rx_status.cls <= rx_class;
            end
         end
      end
   end
endmodule // efh_frame

// ===== design/efh_pkg.sv
/*
 * Constants and types of the frame block.
 * Assumes one clock.
 */
// Function
// R1: Transmit adds seven preamble bytes and delimiter; receive strips both.
// R2: Preamble handling needs no host action.
// R3: Received pad and checksum bytes pass on with the frame.
// R4: First-byte low bit set means multicast.
// R5: All-ones destination is broadcast.
// R6: First-byte low bit clear means unicast.
// R7: Receive filters select by address class.
// R8: Host puts the destination in every transmit frame.
// R9: Host, not device, supplies the source address.
// R10: Type/length up to 05dc is a length, else a type.
// R11: Over 1500 payload bytes only with huge frame enable.
// R12: Minimum 60 bytes before checksum, 64 with it.
// R13: Pad configuration can select zero padding of short frames.
// R14: Undersize transmit frames are still sent without padding.
// R15: Received frames under 18 bytes are dropped.
// R16: Frames of 18 bytes or more are filtered normally.
// R17: Host rejects received frames under 64 bytes.
// R18: Bad checksum frames dropped when checksum filter enabled. The code still passes them to the host and clears good in o_rx_status.
// R19: Pad configuration can select an appended 32-bit checksum.
// R20: Fields go destination, source, type, payload, pad, checksum.
package efh_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] REG_MAC_CTRL = 8'h00;
   localparam logic [7:0] REG_RX_FILTER = 8'h04;
   localparam logic [7:0] REG_STATION_LO = 8'h08;
   localparam logic [7:0] REG_STATION_HI = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam int PAD_CFG_LSB = 0;
   localparam int HUGE_EN_BIT = 3;
   localparam logic [2:0] PAD_CFG_RESET = 3'h0;
   localparam int PAD_EN_BIT = 0;
   localparam int FLT_UNICAST_BIT = 0;
   localparam int FLT_MULTICAST_BIT = 1;
   localparam int FLT_BROADCAST_BIT = 2;
   localparam int FLT_CRC_BIT = 3;
   localparam int FLT_ENABLE_BIT = 7;
   localparam logic [7:0] RX_FILTER_RESET = 8'h08;

   // ****************************************
   // Frame constants
   // ****************************************
   localparam int CNT_W = 16;
   localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
   localparam logic [7:0] SFD_BYTE = 8'hd5;
   localparam logic [7:0] PAD_BYTE = 8'h00;
   localparam logic [2:0] PREAMBLE_LAST = 3'h6;
   localparam logic [1:0] FCS_LAST = 2'h3;
   localparam logic [CNT_W-1:0] MIN_FRAME_NO_FCS = 16'h003c;
   localparam logic [CNT_W-1:0] MAX_FRAME_NO_FCS = 16'h05ea;
   localparam logic [CNT_W-1:0] MAX_FRAME = 16'h05ee;
   localparam logic [CNT_W-1:0] RUNT_LEN = 16'h0012;
   localparam logic [CNT_W-1:0] DEST_LEN = 16'h0006;
   localparam logic [CNT_W-1:0] TYPE_HI_POS = 16'h000c;
   localparam logic [CNT_W-1:0] TYPE_LO_POS = 16'h000d;
   localparam logic [15:0] TYPE_LEN_MAX = 16'h05dc;
   localparam int DELAY_LEN = 17;
   localparam logic [4:0] DELAY_LAST = 5'h10;
   localparam logic [47:0] BROADCAST_ADDR = 48'hffff_ffff_ffff;
   localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
   localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
   localparam logic [31:0] CRC_RESIDUE = 32'hdebb_20e3;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic [7:0] data;
      logic last;
   } efh_byte_type;

   typedef enum logic [1:0] {
      CLASS_UNICAST = 2'h0,
      CLASS_MULTICAST = 2'h1,
      CLASS_BROADCAST = 2'h3
   } efh_class_type;

   typedef struct packed {
      logic good;
      logic crc_ok;
      logic oversize;
      logic length_field;
      efh_class_type cls;
   } efh_rx_status_type;

   typedef enum logic [5:0] {
      TX_IDLE = 6'h01,
      TX_PRE = 6'h02,
      TX_SFD = 6'h04,
      TX_DATA = 6'h08,
      TX_PAD = 6'h10,
      TX_FCS = 6'h20
   } efh_tx_state_type;

   typedef enum logic [3:0] {
      RX_IDLE = 4'h1,
      RX_PRE = 4'h2,
      RX_DATA = 4'h4,
      RX_FLUSH = 4'h8
   } efh_rx_state_type;

endpackage

// ===== design/efh_crc32.sv
/*
 * Byte-wide frame checksum.
 * Assumes a clear per frame.
 */
module efh_crc32
(
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_clear,
   input wire logic i_valid,
   input wire logic [7:0] i_data,
   output logic [31:0] o_crc
);
   import efh_pkg::*;

   // ****************************************
   // Byte update
   // ****************************************
   function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [7:0] data);
      logic [31:0] c;
      c = crc ^ {24'h000000, data};
      for (int i = 0; i < 8; i++)
      begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst || i_clear)
      begin
         o_crc <= CRC_INIT;
      end
      else if (i_valid)
      begin
         o_crc <= crc_step(o_crc, i_data);
      end
   end
endmodule // efh_crc32

// ===== design/efh_addr_filter.sv
/*
 * Address class and filter.
 * Assumes a stable destination.
 */
module efh_addr_filter
(
   input wire logic [47:0] i_dest,
   input wire logic [47:0] i_station,
   input wire logic [7:0] i_filter_ctrl,
   output efh_pkg::efh_class_type o_class,
   output logic o_accept
);
   import efh_pkg::*;

   // ****************************************
   // Classification and filter
   // ****************************************
   always_comb
   begin
      if (i_dest == BROADCAST_ADDR)
      begin
         o_class = CLASS_BROADCAST; // see R5
      end
      else if (i_dest[40])
      begin
         o_class = CLASS_MULTICAST; // see R4
      end
      else
      begin
         o_class = CLASS_UNICAST; // see R6
      end
   end

   always_comb
   begin
      if (!i_filter_ctrl[FLT_ENABLE_BIT])
      begin
         o_accept = 1'b1;
      end
      else
      begin
         case (o_class)
            CLASS_BROADCAST: o_accept = i_filter_ctrl[FLT_BROADCAST_BIT]; // see R7
            CLASS_MULTICAST: o_accept = i_filter_ctrl[FLT_MULTICAST_BIT]; // see R7
            default: o_accept = i_filter_ctrl[FLT_UNICAST_BIT] && (i_dest == i_station); // see R7
         endcase
      end
   end
endmodule // efh_addr_filter

// ===== tb/efh_monitor.sv
/* Port checker for efh_frame.
   Assumes a bind from the bench top. */
module efh_monitor
(
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire efh_pkg::efh_byte_type i_tx_byte,
   input wire logic i_tx_valid,
   input wire logic o_tx_ready,
   input wire logic [7:0] o_line_tx_data,
   input wire logic o_line_tx_en,
   input wire logic i_line_rx_dv,
   input wire efh_pkg::efh_byte_type o_rx_byte,
   input wire logic o_rx_valid,
   input wire logic o_rx_end,
   input wire efh_pkg::efh_rx_status_type o_rx_status
);
   timeunit 1ns;
   timeprecision 1ps;
   import efh_pkg::*;
   logic [10:0] tx_cnt_reg;
   logic [10:0] rx_cnt_reg;
   logic pad_reg;
   logic dst0_reg;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_sys_rst);
   always_ff @(posedge i_sys_clk)
   begin
      tx_cnt_reg <= o_line_tx_en ? tx_cnt_reg + 11'h1 : 11'h0;
      rx_cnt_reg <= i_line_rx_dv ? rx_cnt_reg + 11'h1 : 11'h0;
      if ($rose(o_rx_valid) && rx_cnt_reg != 11'h0)
         dst0_reg <= o_rx_byte.data[0];
   end
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         pad_reg <= 1'b0;
      else if (i_reg_wr && i_reg_addr == REG_MAC_CTRL)
         pad_reg <= i_reg_wdata[PAD_EN_BIT];
   end
   sequence s_preamble;
      (o_line_tx_data == PREAMBLE_BYTE) [*7] ##1 o_line_tx_data == SFD_BYTE;
   endsequence
   a_pre_seq: assert property ($rose(o_line_tx_en) |-> s_preamble)
      else $error("bad preamble");
   a_ready_sfd: assert property ($rose(o_tx_ready) |-> o_line_tx_data == SFD_BYTE && $past(o_line_tx_en, 7))
      else $error("late ready");
   a_ready_en: assert property (o_tx_ready |-> o_line_tx_en)
      else $error("stray ready");
   a_tx_pass: assert property (o_tx_ready && i_tx_valid |=> o_line_tx_data == $past(i_tx_byte.data))
      else $error("byte altered");
   a_rx_last: assert property (o_rx_end |-> o_rx_valid && o_rx_byte.last)
      else $error("no last byte");
   a_rx_runt: assert property ($rose(o_rx_valid) && rx_cnt_reg != 11'h0 |-> rx_cnt_reg inside {11'd26, 11'd27})
      else $error("early emission");
   a_pad_min: assert property ($fell(o_line_tx_en) && pad_reg |-> tx_cnt_reg >= 11'd72)
      else $error("short pad");
   a_mc_bit: assert property (o_rx_end |-> o_rx_status.cls[0] == dst0_reg)
      else $error("bad class");
endmodule // efh_monitor

// ===== tb/efh_node.sv
/* Far-side node: sends and captures frames.
   Assumes one byte per clock. */
module efh_node
(
   input wire logic i_sys_clk,
   input wire logic [7:0] i_line_tx_data,
   input wire logic i_line_tx_en,
   output logic [7:0] o_line_rx_data,
   output logic o_line_rx_dv
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] txq [$];
   logic busy = 1'b0;
   logic in_frame = 1'b0;
   initial o_line_rx_data = 8'h00;
   initial o_line_rx_dv = 1'b0;
   always @(posedge i_sys_clk)
   begin
      if (!busy)
         o_line_rx_data <= o_line_rx_data + 8'h3b;
      if (!i_line_tx_en)
         in_frame <= 1'b0;
      else if (in_frame)
         txq.push_back(i_line_tx_data);
      else if (i_line_tx_data == 8'hd5)
         in_frame <= 1'b1;
   end
   function automatic logic [31:0] fcs(input logic [7:0] f [$], input int n);
      logic [31:0] c;
      c = 32'hffff_ffff;
      for (int i = 0; i < n; i++)
      begin
         c = c ^ {24'h0, f[i]};
         for (int b = 0; b < 8; b++)
            c = c[0] ? (c >> 1) ^ 32'hedb8_8320 : c >> 1;
      end
      return ~c;
   endfunction
   task automatic send(input logic [47:0] dst, input logic [15:0] tl, input int len, input logic bad);
      logic [7:0] f [$];
      logic [31:0] c;
      f = {};
      for (int i = 0; i < 6; i++)
         f.push_back(dst[47 - 8 * i -: 8]);
      for (int i = 0; i < 6; i++)
         f.push_back(8'h40 + 8'(i));
      f.push_back(tl[15:8]);
      f.push_back(tl[7:0]);
      while (f.size() < len - 4)
         f.push_back(8'(f.size()));
      c = fcs(f, f.size()) ^ {31'h0, bad};
      for (int i = 0; i < 4; i++)
         f.push_back(c[8 * i +: 8]);
      while (f.size() > len)
         void'(f.pop_back());
      busy = 1'b1;
      for (int i = -8; i < f.size(); i++)
      begin
         @(posedge i_sys_clk);
         o_line_rx_dv <= 1'b1;
         o_line_rx_data <= i < -1 ? 8'h55 : (i == -1 ? 8'hd5 : f[i]);
      end
      @(posedge i_sys_clk);
      o_line_rx_dv <= 1'b0;
      busy = 1'b0;
   endtask
endmodule // efh_node

// ===== tb/tb.sv
/* Bench top.
   Assumes efh_node on the line. */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import efh_pkg::*;
   typedef struct {
      logic [7:0] filt;
      logic [47:0] dst;
      logic [15:0] tl;
      int len;
      logic bad;
      logic out;
      logic [1:0] cls;
   } efh_row_type;
   logic i_sys_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [7:0] i_reg_addr = 8'h00;
   logic [31:0] i_reg_wdata = 32'h0;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   efh_byte_type i_tx_byte = '0;
   logic i_tx_valid = 1'b0;
   logic [31:0] o_reg_rdata, d;
   logic o_tx_ready, o_line_tx_en, i_line_rx_dv, o_rx_valid, o_rx_end;
   logic [7:0] o_line_tx_data, i_line_rx_data, rx_first;
   efh_byte_type o_rx_byte;
   efh_rx_status_type o_rx_status, st;
   int num_errors = 0, compares = 0, rx_n = 0, k, n;
   int tx_len [3] = '{64, 20, 24};
   efh_row_type rows [10] = '{
      '{8'h08,48'h0200_0000_0001,16'h002e,64,0,1,2'h0},
      '{8'h08,48'h0100_5e00_0001,16'h0000,18,0,1,2'h1},
      '{8'h08,48'hffff_ffff_ffff,16'h05dd,20,0,1,2'h3},
      '{8'h08,48'h0200_0000_0001,16'h0000,17,0,0,2'h0},
      '{8'h84,48'h0100_5e00_0001,16'h05dc,30,0,0,2'h1},
      '{8'h84,48'hffff_ffff_ffff,16'h05dc,30,0,1,2'h3},
      '{8'h81,48'h0000_0000_0000,16'h0000,30,0,1,2'h0},
      '{8'h81,48'h0200_0000_0001,16'h0000,30,0,0,2'h0},
      '{8'h08,48'h0200_0000_0001,16'h0010,40,1,1,2'h0},
      '{8'h82,48'h3345_6789_abcd,16'h0010,24,0,1,2'h1}};
   efh_frame dut (.i_sys_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
      .i_tx_byte, .i_tx_valid, .o_tx_ready, .o_line_tx_data, .o_line_tx_en, .i_line_rx_data, .i_line_rx_dv,
      .o_rx_byte, .o_rx_valid, .o_rx_end, .o_rx_status);
   efh_node node (.i_sys_clk, .i_line_tx_data(o_line_tx_data), .i_line_tx_en(o_line_tx_en),
      .o_line_rx_data(i_line_rx_data), .o_line_rx_dv(i_line_rx_dv));
   always #4 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk)
   begin
      if (o_rx_valid && rx_n == 0)
         rx_first <= o_rx_byte.data;
      if (o_rx_valid)
         rx_n <= rx_n + 1;
      if (o_rx_end)
         st <= o_rx_status;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      i_reg_addr <= a;
      i_reg_wdata <= v;
      i_reg_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b0;
      @(posedge i_sys_clk);
      d = o_reg_rdata;
   endtask
   task automatic tx_frame(input int len);
      int j;
      j = 0;
      i_tx_valid <= 1'b1;
      while (j < len)
      begin
         i_tx_byte <= '{data: j[7:0] ^ 8'h5a, last: j == len - 1};
         @(posedge i_sys_clk);
         if (o_tx_ready)
            j++;
      end
      i_tx_valid <= 1'b0;
   endtask
   task automatic results;
      $display("errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      num_errors++;
      results;
   end
   initial
   begin
      repeat (8) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      rd(REG_RX_FILTER);
      chk(d, 32'h8);
      wr(8'h20, 32'h5);
      rd(8'h20);
      chk(d, 32'h0);
      foreach (rows[r])
      begin
         wr(REG_RX_FILTER, {24'h0, rows[r].filt});
         rx_n = 0;
         node.send(rows[r].dst, rows[r].tl, rows[r].len, rows[r].bad);
         repeat (30) @(posedge i_sys_clk);
         chk(rx_n, rows[r].out ? rows[r].len : 0);
         if (rows[r].out)
         begin
            chk(st.cls, rows[r].cls);
            chk(st.crc_ok, !rows[r].bad);
            chk(st.length_field, rows[r].tl <= 16'h05dc);
            chk(rx_first, rows[r].dst[47:40]);
         end
      end
      for (int p = 0; p < 3; p++)
      begin
         wr(REG_MAC_CTRL, p == 0 ? 32'h1 : {30'h0, p[1], 1'b0});
         node.txq = {};
         tx_frame(20);
         repeat (60) @(posedge i_sys_clk);
         chk(node.txq.size(), tx_len[p]);
         for (k = 0; k < 20; k++)
            chk(node.txq[k], k[7:0] ^ 8'h5a);
         for (k = 20; k < tx_len[p] - 4; k++)
            chk(node.txq[k], 8'h00);
         n = tx_len[p] - 4;
         if (p != 1)
            chk({node.txq[n + 3], node.txq[n + 2], node.txq[n + 1], node.txq[n]}, node.fcs(node.txq, n));
      end
      results;
   end
endmodule // tb
bind efh_frame efh_monitor mon (.i_sys_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_tx_byte,
   .i_tx_valid, .o_tx_ready, .o_line_tx_data, .o_line_tx_en, .i_line_rx_dv, .o_rx_byte, .o_rx_valid,
   .o_rx_end, .o_rx_status);
